// ---- design/seg_io_ports.sv ----
// two 8-bit general i/o ports shared with lcd segment drivers, apb slave
// assumes pins arrive asynchronously; the lcd controller reads the segment enables
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "seg_io_consts.svh"

// Behaviour
// - first-port direction bit one makes pin output, zero makes it input
// - first-port direction and data act only on pins left to general i/o
// - first-port direction register is write-only and reads as all ones
// - first-port general i/o input pin with pull-up bit one gets pull-up; output and segment pins never do
// - after reset first-port pull-ups are off, pull-up register cleared
// - first-port upper pins are segments for select codes 0100 to 1011
// - first-port lower pins are segments for select codes 0011 to 1010
// - second-port data reads latch for outputs, live pin for inputs; writes store
// - second-port direction bit one makes pin output, zero makes it input
// - second-port direction and data act only on pins left to general i/o
// - second-port direction register is write-only and reads as all ones
// - first-port data reads latch for outputs, live pin for inputs
// - second-port upper pins are segments for select codes 0110 to 1101
// - second-port lower pins are segments for select codes 0101 to 1100
module seg_io_ports (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire seg_io_pkg::byte_type first_port_pin_in,
  output seg_io_pkg::byte_type    first_port_pin_out,
  output seg_io_pkg::byte_type    first_port_pin_oe,
  output seg_io_pkg::byte_type    first_port_pullup_on,
  output seg_io_pkg::byte_type    segment_output_upper_en,
  input  wire seg_io_pkg::byte_type second_port_pin_in,
  output seg_io_pkg::byte_type    second_port_pin_out,
  output seg_io_pkg::byte_type    second_port_pin_oe,
  output seg_io_pkg::byte_type    segment_output_high_en,
  output seg_io_pkg::segsel_type  segment_select
);
  import seg_io_pkg::*;

  state_type q;
  state_type d;

  ////////////////////////////////////////////////////////////////////////////
  // segment ownership per nibble
  function automatic byte_type seg_mask(input segsel_type s, input segsel_type hl, input segsel_type hh,
                                        input segsel_type ll, input segsel_type lh);
    seg_mask = {{4{(s >= hl) && (s <= hh)}}, {4{(s >= ll) && (s <= lh)}}};
  endfunction

  byte_type   p1_seg_m;
  byte_type   p2_seg_m;
  logic       acc;
  logic       mapped;
  logic [7:0] rd;

  always_comb begin
    p1_seg_m = seg_mask(q.segsel, `P1_HI_LO, `P1_HI_HI, `P1_LO_LO, `P1_LO_HI);
    p2_seg_m = seg_mask(q.segsel, `P2_HI_LO, `P2_HI_HI, `P2_LO_LO, `P2_LO_HI);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    // two-flop pin synchronisers; only the second stage is read
    d.p1_pin_s1 = first_port_pin_in;
    d.p1_pin_s2 = q.p1_pin_s1;
    d.p2_pin_s1 = second_port_pin_in;
    d.p2_pin_s2 = q.p2_pin_s1;

    acc    = psel && penable && !q.pready;
    mapped = 1'b1;
    rd     = 8'h00;
    case (paddr)
      `OFS_P1_DATA:   rd = (q.p1_data & q.p1_dir) | (q.p1_pin_s2 & ~q.p1_dir);
      `OFS_P1_DIR:    rd = `WO_READ_VALUE;
      `OFS_P1_PULLUP: rd = q.p1_pull;
      `OFS_P2_DATA:   rd = (q.p2_data & q.p2_dir) | (q.p2_pin_s2 & ~q.p2_dir);
      `OFS_P2_DIR:    rd = `WO_READ_VALUE;
      `OFS_LCD_CTRL:  rd = {4'h0, q.segsel};
      default:        mapped = 1'b0;
    endcase

    // one wait state: pready rises in the second access cycle
    d.pready  = acc;
    d.pslverr = acc && !mapped;
    d.prdata  = (acc && !pwrite) ? {24'h000000, rd} : 32'h00000000;

    if (acc && pwrite && mapped && pstrb[0]) begin
      case (paddr)
        `OFS_P1_DATA:   d.p1_data = pwdata[7:0];
        `OFS_P1_DIR:    d.p1_dir  = pwdata[7:0];
        `OFS_P1_PULLUP: d.p1_pull = pwdata[7:0];
        `OFS_P2_DATA:   d.p2_data = pwdata[7:0];
        `OFS_P2_DIR:    d.p2_dir  = pwdata[7:0];
        `OFS_LCD_CTRL:  d.segsel  = pwdata[`SEGSEL_LSB +: `SEGSEL_W];
        default:        d.segsel  = q.segsel;
      endcase
    end

    // segment-owned pins ignore direction and data
    d.p1_oe  = q.p1_dir & ~p1_seg_m;
    d.p1_out = q.p1_data & ~p1_seg_m;
    d.p1_pu  = q.p1_pull & ~q.p1_dir & ~p1_seg_m;
    d.p1_seg = p1_seg_m;
    d.p2_oe  = q.p2_dir & ~p2_seg_m;
    d.p2_out = q.p2_data & ~p2_seg_m;
    d.p2_seg = p2_seg_m;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.segsel  <= `RST_SEGSEL;
      q.p1_pull <= `RST_BYTE;
    end else begin
      q <= d;
    end
  end

  assign prdata                  = q.prdata;
  assign pready                  = q.pready;
  assign pslverr                 = q.pslverr;
  assign first_port_pin_out      = q.p1_out;
  assign first_port_pin_oe       = q.p1_oe;
  assign first_port_pullup_on    = q.p1_pu;
  assign segment_output_upper_en = q.p1_seg;
  assign second_port_pin_out     = q.p2_out;
  assign second_port_pin_oe      = q.p2_oe;
  assign segment_output_high_en  = q.p2_seg;
  assign segment_select          = q.segsel;
endmodule

// ---- inc/seg_io_consts.svh ----
// register offsets, reset values and segment-select ranges for the shared i/o ports
// assumes inclusion by the package and the design file only
`ifndef SEG_IO_CONSTS_SVH
`define SEG_IO_CONSTS_SVH

`define OFS_P1_DATA   12'h000
`define OFS_P1_DIR    12'h004
`define OFS_P1_PULLUP 12'h008
`define OFS_P2_DATA   12'h00c
`define OFS_P2_DIR    12'h010
`define OFS_LCD_CTRL  12'h014

`define RST_BYTE      8'h00
`define WO_READ_VALUE 8'hff

`define SEGSEL_LSB    0
`define SEGSEL_W      4
`define RST_SEGSEL    4'h0

`define P1_HI_LO      4'h4
`define P1_HI_HI      4'hb
`define P1_LO_LO      4'h3
`define P1_LO_HI      4'ha
`define P2_HI_LO      4'h6
`define P2_HI_HI      4'hd
`define P2_LO_LO      4'h5
`define P2_LO_HI      4'hc

`endif

// ---- inc/seg_io_pkg.sv ----
// types shared by the shared i/o port design
// assumes seg_io_consts.svh on the include path
package seg_io_pkg;
  `include "seg_io_consts.svh"

  typedef logic [7:0] byte_type;
  typedef logic [3:0] segsel_type;

  typedef struct packed {
    byte_type   p1_data;
    byte_type   p1_dir;
    byte_type   p1_pull;
    byte_type   p2_data;
    byte_type   p2_dir;
    segsel_type segsel;
    byte_type   p1_pin_s1;
    byte_type   p1_pin_s2;
    byte_type   p2_pin_s1;
    byte_type   p2_pin_s2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    byte_type   p1_out;
    byte_type   p1_oe;
    byte_type   p1_pu;
    byte_type   p1_seg;
    byte_type   p2_out;
    byte_type   p2_oe;
    byte_type   p2_seg;
  } state_type;
endpackage

// ---- sim/seg_io_props.sv ----
// checker: apb handshake, first-port pin ownership and second-port segment pins left undriven
// assumes bind onto seg_io_ports by port name
`timescale 1ns/1ps
module seg_io_props (
  input wire logic       pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [3:0] segment_select,
  input wire logic [7:0] segment_output_upper_en, first_port_pin_oe, first_port_pullup_on,
  input wire logic [7:0] segment_output_high_en, second_port_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_time: assert property (psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_idle_quiet: assert property (!psel |=> !pready) else $error("stray ready");
  // owners lag the select register by one clock
  a_upper_seg: assert property (segment_output_upper_en[7:4] ==
    {4{$past(segment_select) inside {[4'h4:4'hb]}}}) else $error("upper owner");
  a_lower_seg: assert property (segment_output_upper_en[3:0] ==
    {4{$past(segment_select) inside {[4'h3:4'ha]}}}) else $error("lower owner");
  a_seg_no_drive: assert property ((first_port_pin_oe & segment_output_upper_en) == 8'h00)
    else $error("segment pin driven");
  a_seg_high_quiet: assert property ((second_port_pin_oe & segment_output_high_en) == 8'h00)
    else $error("second segment pin driven");
  a_pull_off_out: assert property
    ((first_port_pullup_on & (first_port_pin_oe | segment_output_upper_en)) == 8'h00) else $error("pull-up on");
  cover property (pslverr);
  cover property (segment_output_upper_en == 8'hff);
  cover property (first_port_pullup_on != 8'h00);
endmodule

// ---- sim/pin_model.sv ----
// partner: level on each port pin as the inputs see it
// assumes the outside world drives weakly, so pull-up wins high
`timescale 1ns/1ps
module pin_model (
  input wire logic [7:0] oe, dout, pu, ext,
  output logic     [7:0] pin
);
  assign pin = (oe & dout) | (~oe & (pu | ext));
endmodule

// ---- sim/testbench.sv ----
// bench: apb reads queued, a monitor compares answers
// assumes seg_io_props and pin_model compiled before
`timescale 1ns/1ps
module testbench;
  import seg_io_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hf, segment_select;
  byte_type first_port_pin_in, first_port_pin_out, first_port_pin_oe, first_port_pullup_on;
  byte_type second_port_pin_in, second_port_pin_out, second_port_pin_oe;
  byte_type segment_output_upper_en, segment_output_high_en, e1 = 0, e2 = 0, d, d2, m1, m2, pu, g1, g2;
  logic [32:0] q[$];
  int failures = 0, n_tests = 0, cyc = 0, seed = 53519;
  seg_io_ports seg_io_ports_i (.*);
  pin_model p1_i (.oe(first_port_pin_oe), .dout(first_port_pin_out), .pu(first_port_pullup_on),
    .ext(e1), .pin(first_port_pin_in));
  pin_model p2_i (.oe(second_port_pin_oe), .dout(second_port_pin_out), .pu(8'h00),
    .ext(e2), .pin(second_port_pin_in));
  always #20 pclk = ~pclk;
  task chk(input logic [32:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w) q.push_back(e);
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // error answers carry no data worth comparing
  always @(posedge pclk) if (pready === 1'b1 && !pwrite) chk({pslverr, prdata & {32{!pslverr}}}, q.pop_front());
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  function byte_type sg(input int s, lo, hi);
    sg = {{4{s >= hi && s <= hi + 7}}, {4{s >= lo && s <= lo + 7}}};
  endfunction
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 0, 33'h0ff);
    apb(0, 12'h010, 0, 33'h0ff);
    apb(0, 12'h008, 0, 33'h000);
    apb(0, 12'h00c, 0, 33'h000);
    apb(0, 12'h018, 0, 33'h100000000);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      d2 = $random(seed);
      m1 = $random(seed);
      m2 = $random(seed);
      e1 <= $random(seed);
      e2 <= $random(seed);
      apb(1, 12'h004, m1, 0);
      apb(1, 12'h000, d, 0);
      apb(1, 12'h010, m2, 0);
      apb(1, 12'h00c, d2, 0);
      repeat (4) @(posedge pclk);
      apb(0, 12'h000, 0, (d & m1) | (e1 & ~m1));
      apb(0, 12'h00c, 0, (d2 & m2) | (e2 & ~m2));
    end
    // a write with byte lane 0 off must leave the register alone
    pstrb <= 4'h0;
    apb(1, 12'h008, 32'h000000ff, 0);
    pstrb <= 4'hf;
    apb(0, 12'h008, 0, 33'h000);
    for (int s = 0; s < 16; s++) begin
      pu = $random(seed);
      apb(1, 12'h014, s, 0);
      apb(1, 12'h008, pu, 0);
      repeat (3) @(posedge pclk);
      #1;
      g1 = sg(s, 3, 4);
      g2 = sg(s, 5, 6);
      chk(segment_output_upper_en, g1);
      chk(segment_output_high_en, g2);
      chk(first_port_pin_oe, m1 & ~g1);
      chk(second_port_pin_oe, m2 & ~g2);
      chk(first_port_pullup_on, pu & ~m1 & ~g1);
      chk(first_port_pin_out, d & ~g1);
      chk(second_port_pin_out, d2 & ~g2);
    end
    tally_and_finish;
  end
endmodule
bind seg_io_ports seg_io_props seg_io_props_i (.*);
